// [design/cpi_top.sv]
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
module cpi_top
	import cpi_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	// Counting logic state
	input wire logic [31:0] count_value_i,
	input wire logic [31:0] measured_value_i,
	input wire cpi_status_t status_i,
	// Control toward the counting logic
	output cpi_ctrl_t control_o,
	output logic gate_o,
	output logic count_halt_o,
	output logic direct_load_o,
	output logic status_reset_o,
	output logic fault_ack_o,
	output logic measurement_mode_o,
	// Captured parameters
	output logic [31:0] load_direct_value_o,
	output logic [31:0] load_prepared_value_o,
	output logic [31:0] compare_one_o,
	output logic [31:0] compare_two_o,
	output cpi_outcfg_t out_cfg_o,
	output logic [31:0] lower_limit_o,
	output logic [31:0] upper_limit_o,
	output logic [15:0] integration_time_o,
	output logic [1:0] meas_out_one_function_o
);

	// Bus address phase
	logic wr_pend, next_wr_pend;
	logic [7:0] wr_addr, next_wr_addr;
	logic [31:0] hrdata, next_hrdata;

	// Output image
	logic [31:0] param_word, next_param_word;
	cpi_ctrl_t ctrl4, next_ctrl4, ctrl4_prev;
	cpi_strobe_t ctrl5, next_ctrl5, ctrl5_prev;
	logic meas_mode, next_meas_mode;

	// Flags
	logic load_status, next_load_status;
	logic load_error, next_load_error;
	logic parameter_fault, next_parameter_fault;
	logic halted, next_halted;
	logic next_count_halt, next_direct_load, next_status_reset, next_fault_ack;

	// Parameters
	logic [31:0] ld_direct, next_ld_direct, ld_prep, next_ld_prep;
	logic [31:0] cmp_one, next_cmp_one, cmp_two, next_cmp_two;
	logic [31:0] lo_lim, next_lo_lim, up_lim, next_up_lim;
	logic [15:0] int_time, next_int_time;
	logic [1:0] meas_fn, next_meas_fn;
	cpi_outcfg_t out_cfg, next_out_cfg;

	logic take;
	cpi_strobe_t rise5;
	cpi_ctrl_t rise4;
	logic loaded, bad;
	logic [7:0] image_b4, image_b5, image_b6;

	always_comb begin
		take = hsel_i && hready_i && (htrans_i == CPI_HTRANS_NONSEQ);
		next_wr_pend = take && hwrite_i;
		next_wr_addr = take ? haddr_i[7:0] : wr_addr;
		image_b4 = {status_i.supply_fault, status_i.output_fault, parameter_fault,
			2'h0, ctrl4.status_reset_request, load_error, load_status};
		image_b5 = {status_i.counting_down_flag, status_i.counting_up_flag, 1'h0,
			status_i.output_two_state, status_i.output_one_state, 1'h0,
			status_i.digital_input_state, status_i.sync_done_flag};
		image_b6 = {status_i.extra_status_flag, 7'h00};
		next_hrdata = hrdata;
		if (take && !hwrite_i) begin
			case (haddr_i[7:0])
				CPI_PARAM_OFS: next_hrdata = param_word;
				CPI_CTRL_OFS: next_hrdata = {16'h0000, ctrl5, ctrl4};
				CPI_IN_VALUE_OFS: next_hrdata = meas_mode ? measured_value_i : count_value_i;
				CPI_IN_STATUS_OFS: next_hrdata = {8'h00, image_b6, image_b5, image_b4};
				CPI_MODE_OFS: next_hrdata = {31'h00000000, meas_mode};
				CPI_LOAD_VAL_OFS: next_hrdata = meas_mode ? lo_lim : ld_direct;
				default: next_hrdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h00000000;
		end else begin
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
		end
	end

	always_comb begin
		next_param_word = param_word;
		next_ctrl4 = ctrl4;
		next_ctrl5 = ctrl5;
		next_meas_mode = meas_mode;
		if (wr_pend) begin
			case (wr_addr)
				CPI_PARAM_OFS: next_param_word = hwdata_i;
				// only bytes 4 and 5 control
				CPI_CTRL_OFS: begin
					next_ctrl4 = cpi_ctrl_t'(hwdata_i[7:0]);
					next_ctrl5 = cpi_strobe_t'(hwdata_i[15:8]);
				end
				CPI_MODE_OFS: next_meas_mode = hwdata_i[0];
				default: next_param_word = param_word;
			endcase
		end
	end

	always_comb begin
		rise5 = ctrl5 & ~ctrl5_prev;
		rise4 = ctrl4 & ~ctrl4_prev;
		loaded = 1'b0;
		bad = 1'b0;
		next_ld_direct = ld_direct;
		next_ld_prep = ld_prep;
		next_cmp_one = cmp_one;
		next_cmp_two = cmp_two;
		next_out_cfg = out_cfg;
		next_lo_lim = lo_lim;
		next_up_lim = up_lim;
		next_int_time = int_time;
		next_meas_fn = meas_fn;
		next_direct_load = 1'b0;
		if (!meas_mode) begin
			if (rise5.load_direct_value) begin
				next_ld_direct = param_word;
				next_direct_load = 1'b1;
				loaded = 1'b1;
			end
			if (rise5.load_prepared_value) begin
				next_ld_prep = param_word;
				loaded = 1'b1;
			end
			if (rise5.load_compare_one) begin
				next_cmp_one = param_word;
				loaded = 1'b1;
			end
			if (rise5.load_compare_two) begin
				next_cmp_two = param_word;
				loaded = 1'b1;
			end
			if (rise5.load_output_behaviour) begin
				if ((param_word & CPI_OUTCFG_RSVD_MASK) != 32'h00000000) begin
					bad = 1'b1;
				end else begin
					next_out_cfg = {param_word[5:4], param_word[1:0],
						param_word[15:8], param_word[23:16]};
					loaded = 1'b1;
				end
			end
		end else begin
			if (rise5.load_direct_value) begin
				if (param_word > up_lim) begin
					bad = 1'b1;
				end else begin
					next_lo_lim = param_word;
					loaded = 1'b1;
				end
			end
			if (rise5.load_prepared_value) begin
				if (param_word < lo_lim) begin
					bad = 1'b1;
				end else begin
					next_up_lim = param_word;
					loaded = 1'b1;
				end
			end
			if (rise5.load_compare_one) begin
				if ((param_word & CPI_INT_TIME_RSVD_MASK) != 32'h00000000) begin
					bad = 1'b1;
				end else begin
					next_int_time = param_word[15:0];
					loaded = 1'b1;
				end
			end
			if (rise5.load_output_behaviour) begin
				if ((param_word & CPI_MEAS_FN_RSVD_MASK) != 32'h00000000) begin
					bad = 1'b1;
				end else begin
					next_meas_fn = param_word[1:0];
					loaded = 1'b1;
				end
			end
		end
	end

	always_comb begin
		next_load_status = load_status;
		next_load_error = load_error;
		next_parameter_fault = parameter_fault;
		next_halted = halted;
		next_count_halt = 1'b0;
		next_status_reset = rise4.status_reset_request;
		next_fault_ack = rise4.external_fault_ack;
		// status reset and fault acknowledge clear
		if (rise4.status_reset_request) begin
			next_load_error = 1'b0;
		end
		if (rise4.external_fault_ack) begin
			next_parameter_fault = 1'b0;
		end
		// toggle on load, error on bad value
		if (loaded) begin
			next_load_status = !load_status;
		end
		if (bad) begin
			next_load_error = 1'b1;
			next_parameter_fault = 1'b1;
		end
		if (!ctrl4.software_gate) begin
			next_halted = 1'b0;
		end else if ((loaded || bad) && !halted) begin
			next_halted = 1'b1;
			next_count_halt = 1'b1;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			param_word <= 32'h00000000;
			ctrl4 <= '0;
			ctrl5 <= '0;
			ctrl4_prev <= '0;
			ctrl5_prev <= '0;
			meas_mode <= 1'b0;
			load_status <= 1'b0;
			load_error <= 1'b0;
			parameter_fault <= 1'b0;
			halted <= 1'b0;
			count_halt_o <= 1'b0;
			direct_load_o <= 1'b0;
			status_reset_o <= 1'b0;
			fault_ack_o <= 1'b0;
			ld_direct <= CPI_DEF_LOAD_DIRECT;
			ld_prep <= CPI_DEF_LOAD_PREPARED;
			cmp_one <= CPI_DEF_COMPARE_ONE;
			cmp_two <= CPI_DEF_COMPARE_TWO;
			out_cfg <= {CPI_DEF_OUT_FN, CPI_DEF_OUT_FN, CPI_DEF_HYST, CPI_DEF_PULSE};
			lo_lim <= CPI_DEF_LOWER_LIMIT;
			up_lim <= CPI_DEF_UPPER_LIMIT;
			int_time <= CPI_DEF_INT_TIME;
			meas_fn <= CPI_DEF_OUT_FN;
		end else begin
			param_word <= next_param_word;
			ctrl4 <= next_ctrl4;
			ctrl5 <= next_ctrl5;
			ctrl4_prev <= ctrl4;
			ctrl5_prev <= ctrl5;
			meas_mode <= next_meas_mode;
			load_status <= next_load_status;
			load_error <= next_load_error;
			parameter_fault <= next_parameter_fault;
			halted <= next_halted;
			count_halt_o <= next_count_halt;
			direct_load_o <= next_direct_load;
			status_reset_o <= next_status_reset;
			fault_ack_o <= next_fault_ack;
			ld_direct <= next_ld_direct;
			ld_prep <= next_ld_prep;
			cmp_one <= next_cmp_one;
			cmp_two <= next_cmp_two;
			out_cfg <= next_out_cfg;
			lo_lim <= next_lo_lim;
			up_lim <= next_up_lim;
			int_time <= next_int_time;
			meas_fn <= next_meas_fn;
		end
	end

	// Zero-wait slave, always OKAY
	assign hreadyout_o = 1'b1;
	assign hresp_o = CPI_HRESP_OKAY;
	assign hrdata_o = hrdata;
	// control byte 4 to the counting logic
	assign control_o = ctrl4;
	assign gate_o = ctrl4.software_gate && !halted;
	assign measurement_mode_o = meas_mode;
	assign load_direct_value_o = ld_direct;
	assign load_prepared_value_o = ld_prep;
	assign compare_one_o = cmp_one;
	assign compare_two_o = cmp_two;
	assign out_cfg_o = out_cfg;
	assign lower_limit_o = lo_lim;
	assign upper_limit_o = up_lim;
	assign integration_time_o = int_time;
	assign meas_out_one_function_o = meas_fn;

endmodule

// [design/cpi_pkg.sv]
package cpi_pkg;

	// Register byte addresses
	localparam logic [7:0] CPI_PARAM_OFS = 8'h00;
	localparam logic [7:0] CPI_CTRL_OFS = 8'h04;
	localparam logic [7:0] CPI_IN_VALUE_OFS = 8'h08;
	localparam logic [7:0] CPI_IN_STATUS_OFS = 8'h0C;
	localparam logic [7:0] CPI_MODE_OFS = 8'h10;
	localparam logic [7:0] CPI_LOAD_VAL_OFS = 8'h14;

	// AHB-Lite encodings
	localparam logic [1:0] CPI_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] CPI_HTRANS_IDLE = 2'h0;
	localparam logic CPI_HRESP_OKAY = 1'h0;

	// Power-on parameter set
	localparam logic [31:0] CPI_DEF_LOAD_DIRECT = 32'h00000000;
	localparam logic [31:0] CPI_DEF_LOAD_PREPARED = 32'h00000000;
	localparam logic [31:0] CPI_DEF_COMPARE_ONE = 32'h00000000;
	localparam logic [31:0] CPI_DEF_COMPARE_TWO = 32'h00000000;
	localparam logic [31:0] CPI_DEF_LOWER_LIMIT = 32'h00000000;
	localparam logic [31:0] CPI_DEF_UPPER_LIMIT = 32'hFFFFFFFF;
	localparam logic [15:0] CPI_DEF_INT_TIME = 16'h000A;
	localparam logic [1:0] CPI_DEF_OUT_FN = 2'h0;
	localparam logic [7:0] CPI_DEF_HYST = 8'h00;
	localparam logic [7:0] CPI_DEF_PULSE = 8'h00;

	// Reserved bits of the output behaviour word
	localparam logic [31:0] CPI_OUTCFG_RSVD_MASK = 32'hFF0000CC;
	// Reserved bits of the measurement-mode output one function word
	localparam logic [31:0] CPI_MEAS_FN_RSVD_MASK = 32'hFFFFFFFC;
	localparam logic [31:0] CPI_INT_TIME_RSVD_MASK = 32'hFFFF0000;

	// Control byte 4, bit 7 first
	typedef struct packed {
		logic external_fault_ack;
		logic output_two_control_enable;
		logic output_two_set;
		logic output_one_control_enable;
		logic output_one_set;
		logic status_reset_request;
		logic sync_enable;
		logic software_gate;
	} cpi_ctrl_t;

	// Control byte 5; in measurement mode bit 0 lower limit, 1 upper, 2 integration
	typedef struct packed {
		logic [2:0] ignored;
		logic load_output_behaviour;
		logic load_compare_two;
		logic load_compare_one;
		logic load_prepared_value;
		logic load_direct_value;
	} cpi_strobe_t;

	// State reported by the counting logic
	typedef struct packed {
		logic supply_fault;
		logic output_fault;
		logic counting_down_flag;
		logic counting_up_flag;
		logic output_two_state;
		logic output_one_state;
		logic digital_input_state;
		logic sync_done_flag;
		logic extra_status_flag;
	} cpi_status_t;

	// Output behaviour settings
	typedef struct packed {
		logic [1:0] output_two_function;
		logic [1:0] output_one_function;
		logic [7:0] hysteresis;
		logic [7:0] pulse_duration;
	} cpi_outcfg_t;

endpackage

// [tb/cpi_top_monitor.sv]
module cpi_top_monitor
	import cpi_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Bus
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic [31:0] hrdata_o,
	// Counting logic
	input wire logic [31:0] count_value_i,
	input wire logic [31:0] measured_value_i,
	input wire cpi_status_t status_i,
	input wire cpi_ctrl_t control_o,
	input wire logic gate_o,
	input wire logic count_halt_o,
	input wire logic direct_load_o,
	input wire logic status_reset_o,
	input wire logic fault_ack_o,
	input wire logic measurement_mode_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	wire logic rd = hsel_i && hready_i && htrans_i == CPI_HTRANS_NONSEQ && !hwrite_i;
	bus_okay_a: assert property (hreadyout_o && hresp_o == CPI_HRESP_OKAY)
		else $error("bus answer wrong");
	value_read_a: assert property (rd && haddr_i[7:0] == CPI_IN_VALUE_OFS |=>
		hrdata_o == ($past(measurement_mode_o) ? $past(measured_value_i) : $past(count_value_i)))
		else $error("value read wrong");
	diag_read_a: assert property (rd && haddr_i[7:0] == CPI_IN_STATUS_OFS |=>
		hrdata_o[7:6] == $past({status_i.supply_fault, status_i.output_fault}) &&
		hrdata_o[15:14] == $past({status_i.counting_down_flag, status_i.counting_up_flag}) &&
		hrdata_o[31:24] == 8'h00) else $error("status read wrong");
	gate_cause_a: assert property (gate_o |-> control_o.software_gate)
		else $error("gate without request");
	halt_pulse_a: assert property (count_halt_o |->
		$past(control_o.software_gate) ##1 (!count_halt_o && !gate_o)) else $error("halt wrong");
	sreset_pulse_a: assert property ($rose(control_o.status_reset_request) |->
		##[1:4] status_reset_o ##1 !status_reset_o) else $error("status reset pulse wrong");
	fault_ack_a: assert property ($rose(control_o.external_fault_ack) |->
		##[1:4] fault_ack_o ##1 !fault_ack_o) else $error("fault ack pulse wrong");
	direct_mode_a: assert property (direct_load_o |-> !measurement_mode_o)
		else $error("direct load in measurement");
	cover property (count_halt_o);
	cover property (direct_load_o);
	cover property (fault_ack_o);
endmodule

bind cpi_top cpi_top_monitor mon_u (.clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel_i),
	.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
	.count_value_i(count_value_i), .measured_value_i(measured_value_i), .status_i(status_i),
	.control_o(control_o), .gate_o(gate_o), .count_halt_o(count_halt_o),
	.direct_load_o(direct_load_o), .status_reset_o(status_reset_o), .fault_ack_o(fault_ack_o),
	.measurement_mode_o(measurement_mode_o));

// [tb/cpi_gw_model.sv]
module cpi_gw_model
	import cpi_pkg::*;
(
	// Clock
	input wire logic clock_i,
	// AHB-Lite master
	input wire logic hready_i,
	input wire logic [31:0] hrdata_i,
	output logic [31:0] haddr_o,
	output logic [1:0] htrans_o,
	output logic hwrite_o,
	output logic [31:0] hwdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic hung = 1'h0;
	initial begin
		haddr_o = 32'h0;
		htrans_o = CPI_HTRANS_IDLE;
		hwrite_o = 1'h0;
		hwdata_o = 32'h0;
	end
	task automatic phase();
		int n;
		n = 0;
		@(posedge clock_i);
		while (hready_i !== 1'h1 && n < 64) begin
			@(posedge clock_i);
			n++;
		end
		if (n == 64) hung = 1'h1;
	endtask
	// Image words, control only in bytes 4-5
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		haddr_o <= {24'h0, a};
		htrans_o <= CPI_HTRANS_NONSEQ;
		hwrite_o <= w;
		phase();
		htrans_o <= CPI_HTRANS_IDLE;
		hwdata_o <= w ? d : ~hwdata_o;
		phase();
		q = hrdata_i;
	endtask
endmodule

// [tb/counter_process_image_tb.sv]
module counter_process_image_tb
	import cpi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 1'h0;
	logic rst_i = 1'h1;
	logic [31:0] cnt = 32'h0;
	logic [31:0] meas = 32'h0;
	cpi_status_t st = 9'h000;
	wire logic hrdy;
	logic [31:0] haddr, hwdata, hrdata, q, oe, ldd, ldp, c1, c2, lo, up;
	logic [1:0] htrans, mfn;
	logic hwrite, gate, mmode;
	cpi_ctrl_t ctl;
	cpi_outcfg_t ocfg;
	logic [15:0] itm;
	logic [7:0] cb4 = 8'h00;
	logic ls = 1'h0;
	logic le = 1'h0;
	logic pf = 1'h0;
	logic [31:0] ev [5];
	int mismatches = 0;
	int tests_run = 0;
	always #20 clock_i = ~clock_i;
	cpi_gw_model gw_u (.clock_i(clock_i), .hready_i(hrdy), .hrdata_i(hrdata), .haddr_o(haddr),
		.htrans_o(htrans), .hwrite_o(hwrite), .hwdata_o(hwdata));
	cpi_top dut_u (.clock_i(clock_i), .rst_i(rst_i), .hsel_i(1'h1), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
		.hreadyout_o(hrdy), .hresp_o(), .hrdata_o(hrdata), .count_value_i(cnt),
		.measured_value_i(meas), .status_i(st), .control_o(ctl), .gate_o(gate), .count_halt_o(),
		.direct_load_o(), .status_reset_o(), .fault_ack_o(), .measurement_mode_o(mmode),
		.load_direct_value_o(ldd), .load_prepared_value_o(ldp), .compare_one_o(c1),
		.compare_two_o(c2), .out_cfg_o(ocfg), .lower_limit_o(lo), .upper_limit_o(up),
		.integration_time_o(itm), .meas_out_one_function_o(mfn));
	task automatic results();
		$display("Comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		gw_u.xfer(w, a, d, q);
		if (gw_u.hung) begin
			mismatches++;
			$display("ERROR %0t: bus timeout", $time);
			results();
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic wctl(input logic [7:0] b5);
		bus(1'h1, CPI_CTRL_OFS, {16'h0, b5, cb4});
		repeat (4) @(posedge clock_i);
	endtask
	task automatic ld(input int b, input logic [31:0] v);
		bus(1'h1, CPI_PARAM_OFS, v);
		wctl(8'(1 << b));
		wctl(8'h00);
	endtask
	function automatic logic [31:0] diag();
		return {8'h00, st.extra_status_flag, 7'h00, st.counting_down_flag, st.counting_up_flag,
			1'h0, st.output_two_state, st.output_one_state, 1'h0, st.digital_input_state,
			st.sync_done_flag, st.supply_fault, st.output_fault, pf, 2'h0, cb4[2], le, ls};
	endfunction
	initial begin
		void'($urandom(67));
		repeat (16) @(posedge clock_i);
		rst_i <= 1'h0;
		@(posedge clock_i);
		chk(up, CPI_DEF_UPPER_LIMIT);
		chk({16'h0, itm}, {16'h0, CPI_DEF_INT_TIME});
		rdc(CPI_MODE_OFS, 32'h0);
		rdc(8'h1C, 32'h0);
		$display("reset test done");
		repeat (4) begin
			@(posedge clock_i);
			cnt <= $urandom;
			meas <= $urandom;
			st <= cpi_status_t'(9'($urandom));
			@(posedge clock_i);
			rdc(CPI_IN_VALUE_OFS, cnt);
			rdc(CPI_IN_STATUS_OFS, diag());
			bus(1'h1, CPI_MODE_OFS, 32'h1);
			rdc(CPI_IN_VALUE_OFS, meas);
			bus(1'h1, CPI_MODE_OFS, 32'h0);
		end
		$display("input image test done");
		repeat (8) begin
			cb4 = 8'($urandom);
			wctl(8'h00);
			chk({24'h0, ctl}, {24'h0, cb4});
			chk({31'h0, gate}, {31'h0, cb4[0]});
			rdc(CPI_CTRL_OFS, {24'h0, cb4});
			rdc(CPI_IN_STATUS_OFS, diag());
		end
		cb4 = 8'h01;
		wctl(8'h00);
		$display("control test done");
		for (int b = 0; b < 5; b++) begin
			ev[b] = $urandom & (b == 4 ? ~CPI_OUTCFG_RSVD_MASK : 32'hFFFFFFFF);
			ld(b, ev[b]);
			ls = ~ls;
			chk({31'h0, gate}, 32'h0);
		end
		oe = {12'h0, ev[4][5:4], ev[4][1:0], ev[4][15:8], ev[4][23:16]};
		chk(ldd, ev[0]);
		chk(ldp, ev[1]);
		chk(c1, ev[2]);
		chk(c2, ev[3]);
		chk({12'h0, ocfg}, oe);
		rdc(CPI_PARAM_OFS, ev[4]);
		rdc(CPI_LOAD_VAL_OFS, ev[0]);
		rdc(CPI_IN_STATUS_OFS, diag());
		$display("load test done");
		ld(4, 32'hFF000000);
		le = 1'h1;
		pf = 1'h1;
		chk({12'h0, ocfg}, oe);
		rdc(CPI_IN_STATUS_OFS, diag());
		cb4 = 8'h05;
		wctl(8'h00);
		le = 1'h0;
		rdc(CPI_IN_STATUS_OFS, diag());
		cb4 = 8'h81;
		wctl(8'h00);
		pf = 1'h0;
		rdc(CPI_IN_STATUS_OFS, diag());
		$display("invalid load test done");
		bus(1'h1, CPI_MODE_OFS, 32'h1);
		ev[0] = $urandom >> 1;
		ev[1] = $urandom | 32'h80000000;
		ev[2] = {16'h0, 16'($urandom)};
		ev[3] = {30'h0, 2'($urandom)};
		for (int b = 0; b < 4; b++) begin
			ld(b == 3 ? 4 : b, ev[b]);
			ls = ~ls;
		end
		chk(lo, ev[0]);
		chk(up, ev[1]);
		chk({16'h0, itm}, ev[2]);
		chk({30'h0, mfn}, ev[3]);
		chk({31'h0, mmode}, 32'h1);
		rdc(CPI_LOAD_VAL_OFS, ev[0]);
		rdc(CPI_IN_STATUS_OFS, diag());
		ld(2, 32'h00010000);
		le = 1'h1;
		pf = 1'h1;
		chk({16'h0, itm}, ev[2]);
		rdc(CPI_IN_STATUS_OFS, diag());
		$display("measurement test done");
		rst_i <= 1'h1;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'h0;
		@(posedge clock_i);
		cb4 = 8'h00;
		ls = 1'h0;
		le = 1'h0;
		pf = 1'h0;
		chk({31'h0, mmode}, 32'h0);
		chk(lo, CPI_DEF_LOWER_LIMIT);
		chk(up, CPI_DEF_UPPER_LIMIT);
		chk(ldd, CPI_DEF_LOAD_DIRECT);
		rdc(CPI_IN_STATUS_OFS, diag());
		$display("power loss test done");
		results();
	end
endmodule
